// [rtl/pgoc_top.sv]
// Interpreter of the odd and even pixel gain and offset configuration commands.
// Summary of operation
// - Code 0x80 reads/writes odd gain, length 2.
// - Code 0x84 reads/writes odd offset, length 2.
// - Code 0x82 reads/writes even gain, length 2.
// - Code 0x86 reads/writes even offset, length 2.
// - Write: flag 0, two bytes, no response.
// - Gain is 16 bit, low byte first.
// - Offset is 16 bit, low byte first.
// - Variants one, two: gain 0 to 1023.
// - Variant three: gain 0 to 319.
// - Variants one, two: offset 0 to 255.
// - Variant three: offset 0 to 1023.
`timescale 1ns/100ps
`include "pgoc_consts.svh"

module pgoc_top #(
	parameter logic [1:0] VARIANT = `PGOC_VARIANT_1
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Command byte stream from the framing layer.
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_abort,
	output logic rx_ready,
	// Response byte stream to the framing layer.
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// Odd pixel channel settings.
	output logic [15:0] odd_gain,
	output logic [15:0] odd_offset,
	// Even pixel channel settings.
	output logic [15:0] even_gain,
	output logic [15:0] even_offset
);

	// True for the four codes that this block owns.
	function automatic logic is_setting(input logic [7:0] c);
		is_setting = (c == `PGOC_CODE_ODD_GAIN) || (c == `PGOC_CODE_ODD_OFFSET) ||
			(c == `PGOC_CODE_EVEN_GAIN) || (c == `PGOC_CODE_EVEN_OFFSET);
	endfunction

	// True for the two gain codes.
	function automatic logic is_gain_code(input logic [7:0] c);
		is_gain_code = (c == `PGOC_CODE_ODD_GAIN) || (c == `PGOC_CODE_EVEN_GAIN);
	endfunction

	logic [1:0] rst_sync_r;
	logic rst_int_n;
	pgoc_pkg::pgoc_top_st_t s_r;
	pgoc_pkg::pgoc_top_st_t s_nxt;
	logic rx_fire;
	logic [15:0] wr_val;
	logic wr_ok;
	logic ser_load;
	logic ser_busy;
	logic [15:0] rd_val;

	// Reset is released through two flops so that every flop behind them leaves reset on one edge.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_int_n = rst_sync_r[1];

	assign rx_fire = rx_valid && s_r.rx_ready;
	assign wr_val = {rx_data, s_r.lo};
	assign ser_load = (s_r.st == pgoc_pkg::PGOC_ST_RESP);

	pgoc_range_check #(
		.VARIANT(VARIANT)
	) u_range (
		.is_gain(is_gain_code(s_r.code)),
		.value(wr_val),
		.in_range(wr_ok)
	);

	// Read-back value selected by the command code.
	always_comb begin
		case (s_r.code)
			`PGOC_CODE_ODD_GAIN: begin
				rd_val = s_r.odd_gain;
			end
			`PGOC_CODE_ODD_OFFSET: begin
				rd_val = s_r.odd_offset;
			end
			`PGOC_CODE_EVEN_GAIN: begin
				rd_val = s_r.even_gain;
			end
			default: begin
				rd_val = s_r.even_offset;
			end
		endcase
	end

	pgoc_resp_ser u_ser (
		.sys_clk(sys_clk),
		.rst_n(rst_int_n),
		.load(ser_load),
		.code(s_r.code),
		.value(rd_val),
		.busy(ser_busy),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready)
	);

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			pgoc_pkg::PGOC_ST_CODE: begin
				if (rx_fire) begin
					s_nxt.code = rx_data;
					s_nxt.st = pgoc_pkg::PGOC_ST_HDR;
				end
			end
			pgoc_pkg::PGOC_ST_HDR: begin
				if (rx_fire) begin
					s_nxt.len = rx_data[`PGOC_LEN_MSB:0];
					if (rx_data[`PGOC_FLAG_BIT] == `PGOC_FLAG_READ) begin
						if (is_setting(s_r.code) && rx_data[`PGOC_LEN_MSB:0] == `PGOC_LEN_SETTING) begin
							s_nxt.st = pgoc_pkg::PGOC_ST_RESP;
						end else begin
							s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
						end
					end else if (rx_data[`PGOC_LEN_MSB:0] == `PGOC_LEN_ZERO) begin
						s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
					end else if (is_setting(s_r.code) &&
						rx_data[`PGOC_LEN_MSB:0] == `PGOC_LEN_SETTING) begin
						s_nxt.st = pgoc_pkg::PGOC_ST_LO;
					end else begin
						// Foreign or malformed frames are drained byte by byte.
						s_nxt.st = pgoc_pkg::PGOC_ST_SKIP;
					end
				end
			end
			pgoc_pkg::PGOC_ST_LO: begin
				if (rx_fire) begin
					s_nxt.lo = rx_data;
					s_nxt.st = pgoc_pkg::PGOC_ST_HI;
				end
			end
			pgoc_pkg::PGOC_ST_HI: begin
				if (rx_fire) begin
					s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
					if (wr_ok) begin
						case (s_r.code)
							`PGOC_CODE_ODD_GAIN: begin
								s_nxt.odd_gain = wr_val;
							end
							`PGOC_CODE_ODD_OFFSET: begin
								s_nxt.odd_offset = wr_val;
							end
							`PGOC_CODE_EVEN_GAIN: begin
								s_nxt.even_gain = wr_val;
							end
							default: begin
								s_nxt.even_offset = wr_val;
							end
						endcase
					end
				end
			end
			pgoc_pkg::PGOC_ST_SKIP: begin
				if (rx_fire) begin
					s_nxt.len = s_r.len - `PGOC_LEN_ONE;
					if (s_r.len == `PGOC_LEN_ONE) begin
						s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
					end
				end
			end
			pgoc_pkg::PGOC_ST_RESP: begin
				s_nxt.st = pgoc_pkg::PGOC_ST_WAIT;
			end
			pgoc_pkg::PGOC_ST_WAIT: begin
				if (!ser_busy) begin
					s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
				end
			end
			default: begin
				s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
			end
		endcase
		// A framing error resynchronises on the next command code.
		if (rx_abort) begin
			s_nxt.st = pgoc_pkg::PGOC_ST_CODE;
		end
		// Input is held off while a response is pending, so reads never overlap.
		s_nxt.rx_ready = (s_nxt.st != pgoc_pkg::PGOC_ST_RESP) &&
			(s_nxt.st != pgoc_pkg::PGOC_ST_WAIT);
	end

	always_ff @(posedge sys_clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			s_r.st <= pgoc_pkg::PGOC_ST_CODE;
			s_r.code <= 8'h00;
			s_r.len <= `PGOC_LEN_ZERO;
			s_r.lo <= 8'h00;
			s_r.odd_gain <= `PGOC_SETTING_RST;
			s_r.odd_offset <= `PGOC_SETTING_RST;
			s_r.even_gain <= `PGOC_SETTING_RST;
			s_r.even_offset <= `PGOC_SETTING_RST;
			s_r.rx_ready <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_ready = s_r.rx_ready;
	assign odd_gain = s_r.odd_gain;
	assign odd_offset = s_r.odd_offset;
	assign even_gain = s_r.even_gain;
	assign even_offset = s_r.even_offset;

	logic hi_fire;
	assign hi_fire = rx_fire && !rx_abort && (s_r.st == pgoc_pkg::PGOC_ST_HI);

	a_odd_gain_store: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && wr_ok && s_r.code == 8'h80) |=> (odd_gain == $past(wr_val)))
		else $error("Odd gain write was not stored.");

	a_odd_offset_store: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && wr_ok && s_r.code == 8'h84) |=> (odd_offset == $past(wr_val)))
		else $error("Odd offset write was not stored.");

	a_even_gain_store: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && wr_ok && s_r.code == 8'h82) |=> (even_gain == $past(wr_val)))
		else $error("Even gain write was not stored.");

	a_read_value_sel: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(ser_load && s_r.code == 8'h86) |=>
		(u_ser.s_r.frame[15:0] == {$past(even_offset[7:0]), $past(even_offset[15:8])}))
		else $error("Even offset read returns the wrong setting.");

	a_write_no_resp: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(rx_fire && s_r.st == pgoc_pkg::PGOC_ST_HDR && !rx_data[7]) |=> !ser_load [*3])
		else $error("A write produced a response.");

	a_read_resp: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(rx_fire && !rx_abort && s_r.st == pgoc_pkg::PGOC_ST_HDR && rx_data == 8'h82 &&
		is_setting(s_r.code)) |=> ser_load ##1 (tx_valid && !rx_ready))
		else $error("Read request was not answered.");

	a_gain_limit: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && is_gain_code(s_r.code) && VARIANT == `PGOC_VARIANT_3 &&
		wr_val > 16'h013f) |-> !wr_ok)
		else $error("Gain above 319 accepted on variant three.");

	a_gain_limit_v12: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && is_gain_code(s_r.code) && VARIANT != `PGOC_VARIANT_3 &&
		wr_val > 16'h03ff) |-> !wr_ok)
		else $error("Gain above 1023 accepted on variants one and two.");

	a_offset_limit_v12: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && !is_gain_code(s_r.code) && VARIANT != `PGOC_VARIANT_3 &&
		wr_val > 16'h00ff) |-> !wr_ok)
		else $error("Offset above 255 accepted on variants one and two.");

	a_offset_limit_v3: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && !is_gain_code(s_r.code) && VARIANT == `PGOC_VARIANT_3 &&
		wr_val > 16'h03ff) |-> !wr_ok)
		else $error("Offset above 1023 accepted on variant three.");

	a_reject_keep: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && !wr_ok) |=> ($stable(odd_gain) && $stable(odd_offset) &&
		$stable(even_gain) && $stable(even_offset)))
		else $error("Out-of-range write changed a setting.");

	a_parity_keep: assert property (@(posedge sys_clk) disable iff (!rst_int_n)
		(hi_fire && (s_r.code == 8'h80 || s_r.code == 8'h84)) |=>
		($stable(even_gain) && $stable(even_offset)))
		else $error("Odd write disturbed the even channel.");

	c_write_ok: cover property (@(posedge sys_clk) disable iff (!rst_int_n)
		hi_fire && wr_ok);
	c_write_reject: cover property (@(posedge sys_clk) disable iff (!rst_int_n)
		hi_fire && !wr_ok);
	c_read_done: cover property (@(posedge sys_clk) disable iff (!rst_int_n)
		ser_load ##1 ser_busy [*4] ##1 !ser_busy);
	c_skip: cover property (@(posedge sys_clk) disable iff (!rst_int_n)
		s_r.st == pgoc_pkg::PGOC_ST_SKIP && rx_fire);

endmodule

// [rtl/pgoc_consts.svh]
// Command codes, lengths, value limits and reset values of the gain and offset commands.
`ifndef PGOC_CONSTS_SVH
`define PGOC_CONSTS_SVH

`define PGOC_CODE_ODD_GAIN 8'h80
`define PGOC_CODE_EVEN_GAIN 8'h82
`define PGOC_CODE_ODD_OFFSET 8'h84
`define PGOC_CODE_EVEN_OFFSET 8'h86

`define PGOC_FLAG_BIT 7
`define PGOC_LEN_MSB 6
`define PGOC_FLAG_READ 1'b1
`define PGOC_FLAG_WRITE 1'b0
`define PGOC_LEN_SETTING 7'h02
`define PGOC_LEN_ZERO 7'h00
`define PGOC_LEN_ONE 7'h01

`define PGOC_VARIANT_1 2'h0
`define PGOC_VARIANT_2 2'h1
`define PGOC_VARIANT_3 2'h2

`define PGOC_GAIN_MAX_V12 16'h03ff
`define PGOC_GAIN_MAX_V3 16'h013f
`define PGOC_OFFSET_MAX_V12 16'h00ff
`define PGOC_OFFSET_MAX_V3 16'h03ff

`define PGOC_SETTING_RST 16'h0000
`define PGOC_FRAME_RST 32'h0000_0000
`define PGOC_IDX_LAST 2'h3

`endif

// [rtl/pgoc_pkg.sv]
// Types shared by the gain and offset command interpreter.
package pgoc_pkg;

	typedef enum logic [2:0] {
		PGOC_ST_CODE,
		PGOC_ST_HDR,
		PGOC_ST_LO,
		PGOC_ST_HI,
		PGOC_ST_SKIP,
		PGOC_ST_RESP,
		PGOC_ST_WAIT
	} pgoc_state_t;

	typedef struct packed {
		pgoc_state_t st;
		logic [7:0] code;
		logic [6:0] len;
		logic [7:0] lo;
		logic [15:0] odd_gain;
		logic [15:0] odd_offset;
		logic [15:0] even_gain;
		logic [15:0] even_offset;
		logic rx_ready;
	} pgoc_top_st_t;

	typedef struct packed {
		logic busy;
		logic [1:0] idx;
		logic [31:0] frame;
	} pgoc_ser_st_t;

endpackage

// [rtl/pgoc_range_check.sv]
// Range check of a written gain or offset value for the selected model variant.
`timescale 1ns/100ps
`include "pgoc_consts.svh"

module pgoc_range_check #(
	parameter logic [1:0] VARIANT = `PGOC_VARIANT_1
) (
	// Value under test.
	input wire logic is_gain,
	input wire logic [15:0] value,
	// Verdict.
	output logic in_range
);

	logic [15:0] limit;

	always_comb begin
		if (VARIANT == `PGOC_VARIANT_3) begin
			limit = is_gain ? `PGOC_GAIN_MAX_V3 : `PGOC_OFFSET_MAX_V3;
		end else begin
			limit = is_gain ? `PGOC_GAIN_MAX_V12 : `PGOC_OFFSET_MAX_V12;
		end
		in_range = (value <= limit);
	end

endmodule

// [rtl/pgoc_resp_ser.sv]
// Serialiser that sends one four-byte read response frame.
`timescale 1ns/100ps
`include "pgoc_consts.svh"

module pgoc_resp_ser (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Load of one response.
	input wire logic load,
	input wire logic [7:0] code,
	input wire logic [15:0] value,
	output logic busy,
	// Byte stream towards the framing layer.
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready
);

	pgoc_pkg::pgoc_ser_st_t s_r;
	pgoc_pkg::pgoc_ser_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!s_r.busy && load) begin
			s_nxt.frame = {code, `PGOC_FLAG_WRITE, `PGOC_LEN_SETTING, value[7:0], value[15:8]};
			s_nxt.busy = 1'b1;
			s_nxt.idx = 2'h0;
		end else if (s_r.busy && tx_ready) begin
			s_nxt.frame = {s_r.frame[23:0], 8'h00};
			s_nxt.idx = s_r.idx + 2'h1;
			if (s_r.idx == `PGOC_IDX_LAST) begin
				s_nxt.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.busy <= 1'b0;
			s_r.idx <= 2'h0;
			s_r.frame <= `PGOC_FRAME_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy = s_r.busy;
	assign tx_valid = s_r.busy;
	assign tx_data = s_r.frame[31:24];

	a_resp_code_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!s_r.busy && load) |=> (tx_valid && tx_data == $past(code)))
		else $error("Response does not open with the command code.");

	a_resp_len_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(tx_valid && tx_ready && s_r.idx == 2'h0) |=> (tx_data == 8'h02))
		else $error("Response header byte is not flag 0, length 2.");

endmodule

// [tb/pgoc_host_model.sv]
// Host side model that frames commands and collects response bytes.
`timescale 1ns/100ps

module pgoc_host_model (
	// Clock.
	input wire logic sys_clk,
	// Command bytes towards the device.
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	// Response bytes from the device.
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic [7:0] resp_q[$];

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end

	// Bytes go out whole and in frame order.
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		rx_valid = 1'b1;
		rx_data = b;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rx_ready !== 1'b1 && n < 50);
		@(negedge sys_clk);
	endtask

	// A released data line shows the inverse, so stale bytes cannot pass.
	task automatic idle();
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask

	// The sink stalls every other cycle when slow.
	always @(negedge sys_clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// Response bytes kept in arrival order.
	always @(posedge sys_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			resp_q.push_back(tx_data);
		end
	end
endmodule

// [tb/test_pixel_gain_offset_commands.sv]
// Self-checking bench of the gain and offset command interpreter.
`timescale 1ns/100ps

module test_pixel_gain_offset_commands;
	logic sys_clk;
	logic rst_n;
	logic rx_abort;
	logic rx_valid, rx_ready, tx_valid, tx_ready;
	logic rx_ready3, tx_valid3;
	logic [7:0] rx_data, tx_data, tx_data3;
	logic [7:0] q3[$];
	logic [15:0] s1[4];
	logic [15:0] s3[4];
	logic [15:0] e1[4] = '{default: 16'h0000};
	logic [15:0] e3[4] = '{default: 16'h0000};
	logic [7:0] codes[4] = '{8'h80, 8'h84, 8'h82, 8'h86};
	logic [15:0] vals[7] = '{16'h013f, 16'h0140, 16'h00ff, 16'h0100, 16'h03ff, 16'h0400, 16'hffff};
	int num_errors = 0;
	int num_checks = 0;

	always #12.5 sys_clk = ~sys_clk;

	pgoc_top #(.VARIANT(2'h0)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_abort(rx_abort), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.odd_gain(s1[0]), .odd_offset(s1[1]), .even_gain(s1[2]), .even_offset(s1[3]));

	// Variant three shares the stream; it moves in step because timing never depends on range.
	pgoc_top #(.VARIANT(2'h2)) uut_v3 (.sys_clk(sys_clk), .rst_n(rst_n),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_abort(rx_abort), .rx_ready(rx_ready3),
		.tx_valid(tx_valid3), .tx_data(tx_data3), .tx_ready(tx_ready),
		.odd_gain(s3[0]), .odd_offset(s3[1]), .even_gain(s3[2]), .even_offset(s3[3]));

	pgoc_host_model host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// Variant three responses are kept apart so that their values are judged too.
	always @(posedge sys_clk) begin
		if (tx_valid3 === 1'b1 && tx_ready === 1'b1) begin
			q3.push_back(tx_data3);
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	function automatic logic [15:0] lim(input bit v3, input int i);
		if (i % 2 == 0) return v3 ? 16'h013f : 16'h03ff;
		return v3 ? 16'h03ff : 16'h00ff;
	endfunction

	task automatic check_all();
		for (int i = 0; i < 4; i++) begin
			check("setting_v1", s1[i], e1[i]);
			check("setting_v3", s3[i], e3[i]);
		end
	endtask

	task automatic wr(input int i, input logic [15:0] v);
		host.resp_q.delete();
		host.send(codes[i]);
		host.send(8'h02);
		host.send(v[7:0]);
		host.send(v[15:8]);
		host.idle();
		// Expected store follows the variant limits.
		if (v <= lim(1'b0, i)) e1[i] = v;
		if (v <= lim(1'b1, i)) e3[i] = v;
		repeat (4) @(negedge sys_clk);
		check("write_reply", 16'(host.resp_q.size()), 16'h0000);
		check_all();
	endtask

	task automatic rd(input int i);
		int n;
		n = 0;
		host.resp_q.delete();
		q3.delete();
		host.send(codes[i]);
		host.send(8'h82);
		host.idle();
		check("rd_hold", {14'h0000, rx_ready, rx_ready3}, 16'h0000);
		while (host.resp_q.size() < 4 && n < 60) begin
			@(negedge sys_clk);
			n++;
		end
		check("resp_len", 16'(host.resp_q.size()), 16'h0004);
		if (host.resp_q.size() == 4) begin
			check("resp_code", {8'h00, host.resp_q[0]}, {8'h00, codes[i]});
			check("resp_hdr", {8'h00, host.resp_q[1]}, 16'h0002);
			check("resp_value", {host.resp_q[3], host.resp_q[2]}, e1[i]);
		end
		check("resp_len_v3", 16'(q3.size()), 16'h0004);
		if (q3.size() == 4) begin
			check("resp_value_v3", {q3[3], q3[2]}, e3[i]);
		end
		@(negedge sys_clk);
		check("rd_release", {14'h0000, rx_ready, rx_ready3}, 16'h0003);
		check("tx_idle", {14'h0000, tx_valid, tx_valid3}, 16'h0000);
	endtask

	task automatic t_channels();
		for (int i = 0; i < 4; i++) begin
			wr(i, (i % 2 == 0) ? 16'h0123 + 16'(i) : 16'h00a5 + 16'(i));
		end
		for (int i = 0; i < 4; i++) begin
			host.slow = i[0];
			rd(i);
		end
	endtask

	task automatic t_range();
		for (int k = 0; k < 7; k++) begin
			for (int i = 0; i < 4; i++) begin
				wr(i, vals[k]);
			end
		end
		host.slow = 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(i);
		end
		host.slow = 1'b0;
	endtask

	task automatic t_abort();
		host.send(codes[0]);
		host.send(8'h02);
		host.idle();
		rx_abort = 1'b1;
		@(negedge sys_clk);
		rx_abort = 1'b0;
		wr(1, 16'h0033);
	endtask

	task automatic t_unknown();
		host.resp_q.delete();
		host.send(8'h81);
		host.send(8'h02);
		host.send(8'hff);
		host.send(8'hff);
		host.send(8'h81);
		host.send(8'h82);
		host.idle();
		repeat (10) @(negedge sys_clk);
		check("unknown_reply", 16'(host.resp_q.size()), 16'h0000);
		check_all();
		rd(2);
	endtask

	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		rx_abort = 1'b0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		check_all();
		t_channels();
		t_range();
		t_abort();
		t_unknown();
		close_out();
	end

	// Watchdog well beyond the few hundred cycles the run needs.
	initial begin
		#(8000 * 25);
		num_errors++;
		close_out();
	end
endmodule
